// ---- lsc_ctrl.v ----
// Light sensor serial slave, command decoder and measurement timer
`timescale 1ns/1ps
`default_nettype none
`include "lsc_defines.vh"
module lsc_ctrl #(
  parameter OSC_DIV     = `LSC_OSC_DIV,     // System clocks per oscillator tick
  parameter FINE_UNIT   = `LSC_FINE_UNIT,   // Oscillator ticks per integration step, fine
  parameter COARSE_UNIT = `LSC_COARSE_UNIT  // Oscillator ticks per integration step, coarse
) (
  input  wire        clk_sys,     // 50 MHz system clock
  input  wire        nrst,        // Power-on reset, active low
  input  wire        io_ref_n_ok, // Reference pin level; low holds the reset
  input  wire        scl_i,       // Serial clock pin
  input  wire        sda_i,       // Serial data pin level
  output wire        sda_o,       // Serial data output value, always low
  output reg         sda_oe,      // Serial data pull-down enable
  input  wire        addr_sel,    // Slave address select pin
  input  wire [15:0] adc_count,   // Converter count at end of integration
  output reg  [15:0] result_q,    // Illuminance result register
  output reg  [7:0]  integration_time_bits, // Integration time register
  output reg         powered_q,   // High while powered up
  output reg         meas_busy_q, // High while a measurement runs
  output reg  [1:0]  res_mode_q,  // Resolution of the current measurement
  output reg         cont_mode_q  // High for repeated measurement
);
  localparam S_IDLE  = 3'h0;
  localparam S_ADDR  = 3'h1;
  localparam S_ACKA  = 3'h2;
  localparam S_WR    = 3'h3;
  localparam S_ACKW  = 3'h4;
  localparam S_RD    = 3'h5;
  localparam S_RACK  = 3'h6;
  localparam S_WAIT  = 3'h7;

  wire rst_n = nrst & io_ref_n_ok;

  wire [2:0] pins_s;
  lsc_sync2 #(.W(3)) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     ({scl_i, sda_i, addr_sel}),
    .dout    (pins_s)
  );
  wire scl_s  = pins_s[2];
  wire sda_s  = pins_s[1];
  wire addr_s = pins_s[0];

  reg scl_q;
  reg sda_q;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_c  = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_c   = scl_s & scl_q & ~sda_q & sda_s;
  wire [6:0] my_addr = addr_s ? `LSC_ADDR_HI : `LSC_ADDR_LO;

  // Serial slave
  reg [2:0] st_q;
  reg [3:0] bit_cnt_q;
  reg [7:0] shift_q;
  reg [7:0] tx_q;
  reg       rw_q;
  reg       got_cmd_q;
  reg       low_next_q;
  reg       rack_ok_q;
  reg       cmd_stb;
  reg [7:0] cmd_q;

  assign sda_o = 1'b0;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= S_IDLE;
      bit_cnt_q  <= 4'h0;
      shift_q    <= 8'h00;
      tx_q       <= 8'h00;
      rw_q       <= 1'b0;
      got_cmd_q  <= 1'b0;
      low_next_q <= 1'b0;
      rack_ok_q  <= 1'b0;
      cmd_stb    <= 1'b0;
      cmd_q      <= 8'h00;
      sda_oe     <= 1'b0;
    end else begin
      cmd_stb <= 1'b0;
      if (stop_c) begin
        st_q   <= S_IDLE;
        sda_oe <= 1'b0;
      end else if (start_c) begin
        st_q      <= S_ADDR;
        bit_cnt_q <= 4'h0;
        got_cmd_q <= 1'b0;
        sda_oe    <= 1'b0;
      end else begin
        case (st_q)
          S_ADDR, S_WR: begin
            if (scl_rise) begin
              shift_q   <= {shift_q[6:0], sda_s};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall && bit_cnt_q == 4'h8) begin
              bit_cnt_q <= 4'h0;
              if (st_q == S_ADDR) begin
                if (shift_q[7:1] == my_addr) begin
                  rw_q   <= shift_q[0];
                  sda_oe <= 1'b1;
                  st_q   <= S_ACKA;
                end else begin
                  st_q <= S_IDLE;
                end
              end else if (!got_cmd_q) begin
                cmd_q     <= shift_q;
                cmd_stb   <= 1'b1;
                got_cmd_q <= 1'b1;
                sda_oe    <= 1'b1;
                st_q      <= S_ACKW;
              end else begin
                st_q <= S_WAIT;
              end
            end
          end
          S_ACKA: begin
            if (scl_fall) begin
              if (rw_q) begin
                tx_q       <= result_q[15:8];
                sda_oe     <= ~result_q[15];
                low_next_q <= 1'b1;
                st_q       <= S_RD;
              end else begin
                sda_oe <= 1'b0;
                st_q   <= S_WR;
              end
            end
          end
          S_ACKW: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              st_q   <= S_WR;
            end
          end
          S_RD: begin
            if (scl_fall) begin
              if (bit_cnt_q == 4'h7) begin
                bit_cnt_q <= 4'h0;
                sda_oe    <= 1'b0;
                st_q      <= S_RACK;
              end else begin
                tx_q      <= {tx_q[6:0], 1'b0};
                sda_oe    <= ~tx_q[6];
                bit_cnt_q <= bit_cnt_q + 4'h1;
              end
            end
          end
          S_RACK: begin
            if (scl_rise) begin
              rack_ok_q <= ~sda_s;
            end else if (scl_fall) begin
              if (rack_ok_q) begin
                tx_q       <= low_next_q ? result_q[7:0] : result_q[15:8];
                sda_oe     <= low_next_q ? ~result_q[7] : ~result_q[15];
                low_next_q <= ~low_next_q;
                st_q       <= S_RD;
              end else begin
                st_q <= S_WAIT;
              end
            end
          end
          S_WAIT: begin
            sda_oe <= 1'b0;
          end
          default: begin
            st_q   <= S_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // Oscillator tick from the system clock
  reg [7:0] osc_cnt_q;
  wire      osc_tick = (osc_cnt_q == OSC_DIV[7:0] - 8'h01);
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt_q <= 8'h00;
    end else if (osc_tick) begin
      osc_cnt_q <= 8'h00;
    end else begin
      osc_cnt_q <= osc_cnt_q + 8'h01;
    end
  end

  // Command decoder and measurement timer
  reg  [9:0] unit_cnt_q;
  reg  [7:0] step_cnt_q;
  wire [9:0] unit_len  = (res_mode_q == `LSC_RES_COARSE) ? COARSE_UNIT[9:0] : FINE_UNIT[9:0];
  wire       unit_end  = osc_tick && (unit_cnt_q == unit_len - 10'h001);
  wire       meas_done = meas_busy_q && unit_end &&
                         ({1'b0, step_cnt_q} + 9'h001 >= {1'b0, integration_time_bits});
  wire       is_start  = (cmd_q[7:4] == 4'h1 || cmd_q[7:4] == 4'h2) &&
                         (cmd_q[3:0] == 4'h0 || cmd_q[3:0] == 4'h1 || cmd_q[3:0] == 4'h3);
  wire [1:0] cmd_res   = (cmd_q[1:0] == 2'h3) ? `LSC_RES_COARSE :
                         (cmd_q[0] ? `LSC_RES_HALF : `LSC_RES_FINE);

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      result_q              <= `LSC_RESULT_RESET;
      integration_time_bits <= `LSC_MT_RESET;
      powered_q             <= 1'b0;
      meas_busy_q           <= 1'b0;
      res_mode_q            <= `LSC_RES_FINE;
      cont_mode_q           <= 1'b0;
      unit_cnt_q            <= 10'h000;
      step_cnt_q            <= 8'h00;
    end else if (cmd_stb) begin
      if (cmd_q == `LSC_OP_PDN) begin
        powered_q   <= 1'b0;
        meas_busy_q <= 1'b0;
      end else if (cmd_q == `LSC_OP_PON) begin
        powered_q   <= 1'b1;
        meas_busy_q <= 1'b0;
      end else if (cmd_q == `LSC_OP_CLR) begin
        if (powered_q) begin
          result_q <= `LSC_RESULT_RESET;
        end
      end else if (is_start) begin
        powered_q   <= 1'b1;
        meas_busy_q <= 1'b1;
        cont_mode_q <= (cmd_q[7:4] == 4'h1);
        res_mode_q  <= cmd_res;
        unit_cnt_q  <= 10'h000;
        step_cnt_q  <= 8'h00;
      end else if (cmd_q[7:3] == `LSC_OP_MTH_PFX) begin
        integration_time_bits[7:5] <= cmd_q[2:0];
      end else if (cmd_q[7:5] == `LSC_OP_MTL_PFX) begin
        integration_time_bits[4:0] <= cmd_q[4:0];
      end
    end else if (meas_busy_q && osc_tick) begin
      if (meas_done) begin
        result_q   <= adc_count;
        unit_cnt_q <= 10'h000;
        step_cnt_q <= 8'h00;
        if (!cont_mode_q) begin
          meas_busy_q <= 1'b0;
          powered_q   <= 1'b0;
        end
      end else if (unit_end) begin
        unit_cnt_q <= 10'h000;
        step_cnt_q <= step_cnt_q + 8'h01;
      end else begin
        unit_cnt_q <= unit_cnt_q + 10'h001;
      end
    end
  end
endmodule // lsc_ctrl
`default_nettype wire

// ---- lsc_defines.vh ----
// Constants of the light sensor command controller
`ifndef LSC_DEFINES_VH
`define LSC_DEFINES_VH

`define LSC_OP_PDN        8'h00
`define LSC_OP_PON        8'h01
`define LSC_OP_CLR        8'h07
`define LSC_OP_CONT_FINE  8'h10
`define LSC_OP_CONT_HALF  8'h11
`define LSC_OP_CONT_COARS 8'h13
`define LSC_OP_ONE_FINE   8'h20
`define LSC_OP_ONE_HALF   8'h21
`define LSC_OP_ONE_COARS  8'h23
`define LSC_OP_MTH_PFX    5'h08
`define LSC_OP_MTL_PFX    3'h3

`define LSC_ADDR_HI       7'h5c
`define LSC_ADDR_LO       7'h23

`define LSC_MT_RESET      8'h45
`define LSC_RESULT_RESET  16'h0000

`define LSC_RES_FINE      2'h0
`define LSC_RES_HALF      2'h1
`define LSC_RES_COARSE    2'h2

`define LSC_CLK_KHZ       50000
`define LSC_OSC_KHZ       320
`define LSC_FINE_MS       120
`define LSC_COARSE_MS     16
`define LSC_MT_DEFAULT    69
`define LSC_OSC_DIV       (`LSC_CLK_KHZ / `LSC_OSC_KHZ)
`define LSC_FINE_UNIT     ((`LSC_FINE_MS * `LSC_OSC_KHZ) / `LSC_MT_DEFAULT)
`define LSC_COARSE_UNIT   ((`LSC_COARSE_MS * `LSC_OSC_KHZ) / `LSC_MT_DEFAULT)

`endif

// ---- lsc_sync2.v ----
// Two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module lsc_sync2 #(
  parameter W = 1
) (
  input  wire         clk_sys, // System clock
  input  wire         rst_n,   // Asynchronous reset, active low
  input  wire [W-1:0] din,     // Asynchronous inputs
  output reg  [W-1:0] dout     // Synchronised outputs
);
  reg [W-1:0] meta_q;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {W{1'b1}};
      dout   <= {W{1'b1}};
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule // lsc_sync2
`default_nettype wire

// ---- lsc_ctrl_props.sv ----
// Port checker of the light sensor controller
`timescale 1ns/1ps
`default_nettype none
module lsc_ctrl_props #(parameter OSC_DIV = 4, parameter FINE_UNIT = 3, parameter COARSE_UNIT = 1) (
  input wire logic        clk_sys,     // Clock
  input wire logic        nrst,        // Reset
  input wire logic        io_ref_n_ok, // Reference pin
  input wire logic        scl_i,       // Serial clock
  input wire logic        sda_i,       // Data level
  input wire logic        sda_o,       // Data value
  input wire logic        sda_oe,      // Data pull
  input wire logic        addr_sel,    // Address select
  input wire logic [15:0] adc_count,   // Count
  input wire logic [15:0] result_q,    // Result
  input wire logic [7:0]  integration_time_bits, // Time
  input wire logic        powered_q,   // Powered
  input wire logic        meas_busy_q, // Busy
  input wire logic [1:0]  res_mode_q,  // Mode
  input wire logic        cont_mode_q  // Repeat
);
  default clocking cb @(posedge clk_sys); endclocking
  wire         rst_n = nrst & io_ref_n_ok;
  wire  [31:0] per = integration_time_bits * (res_mode_q == 2'h2 ? COARSE_UNIT : FINE_UNIT) * OSC_DIV;
  logic [31:0] cnt_q;
  // Cycles since the measurement started or last refreshed the result
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      cnt_q <= 32'h0;
    else if (!meas_busy_q || $changed(result_q))
      cnt_q <= 32'h1;
    else
      cnt_q <= cnt_q + 32'h1;
  end
  a_reset_values:
    assert property (disable iff (!rst_n) $rose(rst_n) |-> result_q == 16'h0000 && integration_time_bits == 8'h45)
    else $error("Bad values after reset");
  a_ref_reset:
    assert property (disable iff (!nrst) !io_ref_n_ok |-> !powered_q && !meas_busy_q && result_q == 16'h0000)
    else $error("Reference pin low did not hold reset");
  a_busy_power:
    assert property (disable iff (!rst_n) meas_busy_q |-> powered_q && res_mode_q != 2'h3)
    else $error("Measuring while powered down");
  a_result_src:
    assert property (disable iff (!rst_n) $changed(result_q) |-> result_q == 16'h0000 || result_q == $past(adc_count))
    else $error("Result not taken from the count");
  a_clear_power:
    assert property (disable iff (!rst_n) $changed(result_q) |-> $past(powered_q))
    else $error("Result changed while powered down");
  a_mt_half:
    assert property (disable iff (!rst_n) $changed(integration_time_bits) |->
      $past(integration_time_bits[7:5]) == integration_time_bits[7:5] ||
      $past(integration_time_bits[4:0]) == integration_time_bits[4:0])
    else $error("Both time fields changed at once");
  a_meas_period:
    assert property (disable iff (!rst_n) $changed(result_q) && $past(meas_busy_q) |->
      cnt_q + OSC_DIV + 2 >= per && cnt_q <= per + OSC_DIV + 2)
    else $error("Measurement period wrong");
  a_oe_scl_low:
    assert property (disable iff (!rst_n) $rose(sda_oe) |-> !scl_i && !$past(scl_i, 2))
    else $error("Data pulled while clock high");
  c_single: cover property (disable iff (!rst_n) $fell(meas_busy_q) && !powered_q);
  c_repeat: cover property (disable iff (!rst_n) cont_mode_q && $changed(result_q));
  c_clear: cover property (disable iff (!rst_n) $changed(result_q) && result_q == 16'h0000);
endmodule // lsc_ctrl_props
`default_nettype wire

// ---- lsc_i2c_master.sv ----
// Serial bus master model facing the light sensor controller
`timescale 1ns/1ps
`default_nettype none
module lsc_i2c_master (
  input  wire logic clk_sys, // Pacing clock
  input  wire logic sda_i,   // Resolved data line
  output var  logic scl_o,   // Serial clock, high when idle
  output var  logic sda_low  // High pulls data low
);
  initial scl_o = 1'b1;
  initial sda_low = 1'b0;
  // Start when hi_first, else stop; clock stays high after a stop
  task automatic cond(input logic hi_first);
    repeat (2) @(negedge clk_sys);
    sda_low = hi_first ? 1'b0 : 1'b1;
    repeat (2) @(negedge clk_sys);
    scl_o = 1'b1;
    repeat (4) @(negedge clk_sys);
    sda_low = hi_first;
    repeat (4) @(negedge clk_sys);
    if (hi_first) scl_o = 1'b0;
  endtask
  // Data changes two cycles after the clock fall to keep hold time; 160 ns bit period
  task automatic bit_io(input logic b, output logic r);
    repeat (2) @(negedge clk_sys);
    sda_low = ~b;
    repeat (2) @(negedge clk_sys);
    scl_o = 1'b1;
    repeat (4) @(negedge clk_sys);
    r = sda_i;
    scl_o = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic cmd(input logic [6:0] a, input logic [7:0] op, output logic ok);
    logic k1;
    logic k2;
    cond(1'b1);
    wbyte({a, 1'b0}, k1);
    wbyte(op, k2);
    cond(1'b0);
    ok = k1 & k2;
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] v);
    logic r;
    cond(1'b1);
    wbyte({a, 1'b1}, r);
    for (int i = 15; i >= 0; i--) begin
      bit_io(1'b1, r);
      v[i] = r;
      if (i == 8 || i == 0) bit_io(i == 0, r);
    end
    cond(1'b0);
  endtask
endmodule // lsc_i2c_master
`default_nettype wire

// ---- test_light_sensor_command_control.sv ----
// Self-checking bench of the light sensor command controller
`timescale 1ns/1ps
`default_nettype none
`include "lsc_defines.vh"
module test_light_sensor_command_control;
  logic        clk_sys, nrst, io_ref_n_ok, addr_sel, ack;
  logic [15:0] adc_count, rd;
  wire         scl, sda_low, sda_o, sda_oe, powered_q, meas_busy_q, cont_mode_q;
  wire  [15:0] result_q;
  wire  [7:0]  integration_time_bits;
  wire  [1:0]  res_mode_q;
  wire         sda = ~sda_low & (sda_oe ? sda_o : 1'b1);
  wire  [6:0]  addr = addr_sel ? `LSC_ADDR_HI : `LSC_ADDR_LO;
  int          bad_count = 0, check_count = 0, cyc = 0, n;
  lsc_ctrl #(.OSC_DIV(4), .FINE_UNIT(3), .COARSE_UNIT(1)) lsc_ctrl_inst (.clk_sys(clk_sys), .nrst(nrst),
    .io_ref_n_ok(io_ref_n_ok), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .addr_sel(addr_sel),
    .adc_count(adc_count), .result_q(result_q), .integration_time_bits(integration_time_bits),
    .powered_q(powered_q), .meas_busy_q(meas_busy_q), .res_mode_q(res_mode_q), .cont_mode_q(cont_mode_q));
  lsc_i2c_master lsc_i2c_master_inst (.clk_sys(clk_sys), .sda_i(sda), .scl_o(scl), .sda_low(sda_low));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      stop_test;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] op);
    lsc_i2c_master_inst.cmd(addr, op, ack);
  endtask
  task automatic wait_idle;
    for (n = 0; n < 3000 && meas_busy_q !== 1'b0; n++) @(negedge clk_sys);
  endtask
  task automatic wait_res(input logic [15:0] v);
    for (int i = 0; i < 3000 && result_q !== v; i++) @(negedge clk_sys);
  endtask
  task automatic t_addr;
    chk({powered_q, result_q, integration_time_bits}, 25'h45);
    lsc_i2c_master_inst.cmd(`LSC_ADDR_HI, `LSC_OP_PON, ack);
    chk(ack, 1'b0);
    cmd(`LSC_OP_PON);
    chk({ack, powered_q}, 2'h3);
    addr_sel = 1'b1;
    repeat (4) @(negedge clk_sys);
    cmd(`LSC_OP_PDN);
    chk({ack, powered_q}, 2'h2);
    $display("Test addr done");
  endtask
  // Single and repeated opcodes share the mode field in their low bits
  task automatic t_modes(input logic rep);
    logic [7:0] lo [3] = '{8'h00, 8'h01, 8'h03};
    for (int i = 0; i < 3; i++) begin
      adc_count = {rep, 15'h0390} + 16'(i);
      cmd((rep ? 8'h10 : 8'h20) | lo[i]);
      chk({meas_busy_q, cont_mode_q, res_mode_q}, {1'b1, rep, 2'(i)});
      if (rep) begin
        wait_res(adc_count);
        adc_count = ~adc_count;
        wait_res(adc_count);
        chk({meas_busy_q, result_q}, {1'b1, adc_count});
        cmd(`LSC_OP_PDN);
      end else begin
        wait_idle;
        lsc_i2c_master_inst.rd(addr, rd);
        chk(rd, adc_count);
      end
      chk({powered_q, meas_busy_q, result_q}, {2'h0, adc_count});
    end
    $display("Test modes done");
  endtask
  task automatic t_clear;
    cmd(`LSC_OP_CLR);
    chk(result_q, adc_count);
    cmd(`LSC_OP_PON);
    cmd(`LSC_OP_CLR);
    chk({result_q, integration_time_bits}, 24'h45);
    cmd(8'h44);
    cmd(8'h6a);
    chk(integration_time_bits, 8'h8a);
    adc_count = 16'h2468;
    cmd(`LSC_OP_ONE_COARS);
    wait_idle;
    chk({result_q, 1'(n > 480 && n < 560)}, {16'h2468, 1'b1});
    $display("Test clear done");
  endtask
  task automatic t_refuse;
    logic k;
    lsc_i2c_master_inst.cond(1'b1);
    lsc_i2c_master_inst.wbyte({addr, 1'b0}, k);
    lsc_i2c_master_inst.wbyte(`LSC_OP_PON, k);
    lsc_i2c_master_inst.wbyte(`LSC_OP_PDN, ack);
    lsc_i2c_master_inst.cond(1'b0);
    chk({k, ack, powered_q}, 3'h5);
    io_ref_n_ok = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk({powered_q, result_q, integration_time_bits}, 25'h45);
    io_ref_n_ok = 1'b1;
    $display("Test refuse done");
  endtask
  initial begin
    nrst = 1'b0;
    io_ref_n_ok = 1'b1;
    addr_sel = 1'b0;
    adc_count = 16'h0000;
    repeat (3) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (4) @(negedge clk_sys);
    t_addr;
    t_modes(1'b0);
    t_modes(1'b1);
    t_clear;
    t_refuse;
    stop_test;
  end
endmodule // test_light_sensor_command_control
bind lsc_ctrl lsc_ctrl_props #(.OSC_DIV(OSC_DIV), .FINE_UNIT(FINE_UNIT), .COARSE_UNIT(COARSE_UNIT)) lsc_ctrl_props_inst (
  .clk_sys(clk_sys), .nrst(nrst), .io_ref_n_ok(io_ref_n_ok), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .addr_sel(addr_sel), .adc_count(adc_count), .result_q(result_q),
  .integration_time_bits(integration_time_bits), .powered_q(powered_q), .meas_busy_q(meas_busy_q),
  .res_mode_q(res_mode_q), .cont_mode_q(cont_mode_q));
`default_nettype wire
